// ### hw/gpp_pkg.sv
// gpp_pkg: shared constants for the gpio port pin control block
package gpp_pkg;

	// register selects on the documented register port
	localparam logic [1:0] GPP_SEL_PIN_INPUT    = 2'h0;
	localparam logic [1:0] GPP_SEL_DIRECTION    = 2'h1;
	localparam logic [1:0] GPP_SEL_OUTPUT_VALUE = 2'h2;

	// default port width and values after reset
	localparam int unsigned GPP_PORT_WIDTH    = 8;
	localparam logic [7:0]  GPP_DIR_RESET     = 8'h00;
	localparam logic [7:0]  GPP_OUT_RESET     = 8'h00;
	localparam logic [7:0]  GPP_RD_RESET      = 8'h00;
	localparam logic [7:0]  GPP_UNMAPPED_READ = 8'h00;

	// synchroniser delay, in clock periods, seen from a software write
	localparam int unsigned GPP_SW_READBACK_CYCLES = 1;

endpackage

// ### hw/gpp_sync_if.sv
// gpp_sync_if: pad sample path between the port top and its synchroniser
`timescale 1ns/1ps
interface gpp_sync_if #(
	parameter int unsigned WIDTH = 8
);
	logic [WIDTH-1:0] pad_level;  // raw pad levels toward the synchroniser
	logic [WIDTH-1:0] pin_sync;   // synchronised pin values back to the port

	modport port_side (
		output pad_level,
		input  pin_sync
	);
	modport sync_side (
		input  pad_level,
		output pin_sync
	);
endinterface

// ### hw/gpp_pin_sync.sv
// gpp_pin_sync: two-stage pad input synchroniser, falling then rising edge
`timescale 1ns/1ps
module gpp_pin_sync
	import gpp_pkg::*;
#(
	parameter int unsigned WIDTH = GPP_PORT_WIDTH
) (
	input  wire logic i_clock,          // system clock
	input  wire logic i_nrst,           // async reset, active low
	gpp_sync_if.sync_side sync          // pad levels in, synced values out
);

	typedef struct packed {
		logic [WIDTH-1:0] hold;  // stands in for the latch closed while clock is low
	} gpp_sync_lo_type;

	typedef struct packed {
		logic [WIDTH-1:0] pin;   // pin input register
	} gpp_sync_hi_type;

	gpp_sync_lo_type lo_q;
	gpp_sync_lo_type lo_d;
	gpp_sync_hi_type hi_q;
	gpp_sync_hi_type hi_d;

	// first stage only feeds the second stage
	always_comb begin
		lo_d      = lo_q;
		lo_d.hold = sync.pad_level;
		hi_d      = hi_q;
		hi_d.pin  = lo_q.hold;
	end

	// capture on the falling edge gives the half to one and a half period delay
	always_ff @(negedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			lo_q <= '0;
		end else begin
			lo_q <= lo_d;
		end
	end

	// load the pin input register on the following rising edge
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			hi_q <= '0;
		end else begin
			hi_q <= hi_d;
		end
	end

	assign sync.pin_sync = hi_q.pin;

endmodule

// ### hw/gpp_port.sv
// gpp_port: one general purpose i/o port with direction, value and pin input registers
// What this block does
// - direction bit one makes the pin an output, zero an input.
// - input with value bit one gets a pull-up unless global disable is set.
// - pull-up off when value bit is zero or pin is an output.
// - reset tri-states every pin at once, with no clock needed.
// - output pins drive high for value one, low for value zero.
// - writing one to the pin input location inverts that value bit; zeros ignored.
// - pin input location stores nothing; value and direction are read/write.
// - global pull-up disable turns off every pull-up in the port.
// - synchronised pin value is readable whatever the direction.
// - pad passes a falling-edge hold then a rising-edge register.
// - written value reaches the pin input register one clock later.
// - a single-bit update changes no other pin of the port.
// - pins used by other functions leave the rest usable as plain i/o.
`timescale 1ns/1ps
module gpp_port
	import gpp_pkg::*;
#(
	parameter int unsigned WIDTH = GPP_PORT_WIDTH
) (
	input  wire logic             i_clock,                 // system clock, 20 MHz
	input  wire logic             i_nrst,                  // async reset, active low
	input  wire logic             i_wr_en,                 // register write strobe
	input  wire logic [1:0]       i_wr_sel,                // register written
	input  wire logic [WIDTH-1:0] i_wr_data,               // write data
	input  wire logic [WIDTH-1:0] i_wr_mask,               // bits taking part in write
	input  wire logic             i_rd_en,                 // register read strobe
	input  wire logic [1:0]       i_rd_sel,                // register read
	output logic      [WIDTH-1:0] o_rd_data,               // read data, one cycle later
	input  wire logic             i_global_pullup_disable, // kills all pull-ups
	input  wire logic [WIDTH-1:0] i_pad_in,                // pad input levels
	output logic      [WIDTH-1:0] o_pad_out,               // pad drive level
	output logic      [WIDTH-1:0] o_pad_oe,                // pad drive enable, high drives
	output logic      [WIDTH-1:0] o_pullup_en              // pad pull-up enable
);

	typedef struct packed {
		logic [WIDTH-1:0] port_direction;
		logic [WIDTH-1:0] port_output_value;
		logic [WIDTH-1:0] rd_data;
	} gpp_state_type;

	gpp_state_type state_q;
	gpp_state_type state_d;
	logic [WIDTH-1:0] port_pin_input;

	gpp_sync_if #(.WIDTH(WIDTH)) sync_bus ();

	// pads always feed the synchroniser, also when the pin drives itself
	assign sync_bus.pad_level = i_pad_in;
	assign port_pin_input     = sync_bus.pin_sync;

	gpp_pin_sync #(
		.WIDTH (WIDTH)
	) gpp_pin_sync_inst (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.sync    (sync_bus)
	);

	// masked merge keeps unselected pins untouched
	function automatic logic [WIDTH-1:0] merge_bits(
		input logic [WIDTH-1:0] old_bits,
		input logic [WIDTH-1:0] new_bits,
		input logic [WIDTH-1:0] mask
	);
		merge_bits = (old_bits & ~mask) | (new_bits & mask);
	endfunction

	// register writes and read data capture
	always_comb begin
		state_d = state_q;
		if (i_wr_en) begin
			case (i_wr_sel)
				GPP_SEL_DIRECTION: begin
					state_d.port_direction = merge_bits(state_q.port_direction,
						i_wr_data, i_wr_mask);
				end
				GPP_SEL_OUTPUT_VALUE: begin
					state_d.port_output_value = merge_bits(state_q.port_output_value,
						i_wr_data, i_wr_mask);
				end
				GPP_SEL_PIN_INPUT: begin
					// toggle ignores direction; no storage behind this location
					state_d.port_output_value = state_q.port_output_value
						^ (i_wr_data & i_wr_mask);
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
		if (i_rd_en) begin
			case (i_rd_sel)
				GPP_SEL_PIN_INPUT:    state_d.rd_data = port_pin_input;
				GPP_SEL_DIRECTION:    state_d.rd_data = state_q.port_direction;
				GPP_SEL_OUTPUT_VALUE: state_d.rd_data = state_q.port_output_value;
				default:              state_d.rd_data = WIDTH'(GPP_UNMAPPED_READ);
			endcase
		end
	end

	// async clear releases every pad even with the clock stopped
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q.port_direction    <= WIDTH'(GPP_DIR_RESET);
			state_q.port_output_value <= WIDTH'(GPP_OUT_RESET);
			state_q.rd_data           <= WIDTH'(GPP_RD_RESET);
		end else begin
			state_q <= state_d;
		end
	end

	// pad control is per bit, so other functions on some pins leave the rest alone
	assign o_pad_oe    = state_q.port_direction;
	assign o_pad_out   = state_q.port_output_value;
	assign o_pullup_en = ~state_q.port_direction & state_q.port_output_value
		& {WIDTH{~i_global_pullup_disable}};
	assign o_rd_data   = state_q.rd_data;

	sequence s_dir_write;
		i_wr_en && (i_wr_sel == GPP_SEL_DIRECTION);
	endsequence

	sequence s_out_write;
		i_wr_en && (i_wr_sel == GPP_SEL_OUTPUT_VALUE);
	endsequence

	sequence s_pin_write;
		i_wr_en && (i_wr_sel == GPP_SEL_PIN_INPUT);
	endsequence

	property p_dir_update;
		@(posedge i_clock) disable iff (!i_nrst)
		s_dir_write |=> o_pad_oe == (($past(o_pad_oe) & ~$past(i_wr_mask))
			| ($past(i_wr_data) & $past(i_wr_mask)));
	endproperty
	a_dir_update: assert property (p_dir_update) else $error("direction write wrong");

	property p_out_update;
		@(posedge i_clock) disable iff (!i_nrst)
		s_out_write |=> o_pad_out == (($past(o_pad_out) & ~$past(i_wr_mask))
			| ($past(i_wr_data) & $past(i_wr_mask)));
	endproperty
	a_out_update: assert property (p_out_update) else $error("value write wrong");

	property p_toggle;
		@(posedge i_clock) disable iff (!i_nrst)
		s_pin_write |=> o_pad_out == ($past(o_pad_out)
			^ ($past(i_wr_data) & $past(i_wr_mask)));
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle wrong");

	property p_pin_keeps_dir;
		@(posedge i_clock) disable iff (!i_nrst)
		s_pin_write |=> $stable(o_pad_oe);
	endproperty
	a_pin_keeps_dir: assert property (p_pin_keeps_dir) else $error("toggle moved dir");

	property p_untouched_stable;
		@(posedge i_clock) disable iff (!i_nrst)
		!i_wr_en |=> $stable(o_pad_oe) && $stable(o_pad_out);
	endproperty
	a_untouched_stable: assert property (p_untouched_stable) else $error("drift");

	property p_pullup;
		@(posedge i_clock) disable iff (!i_nrst)
		o_pullup_en == (~o_pad_oe & o_pad_out & {WIDTH{~i_global_pullup_disable}});
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up wrong");

	property p_pullup_off;
		@(posedge i_clock) disable iff (!i_nrst)
		(o_pullup_en & (o_pad_oe | ~o_pad_out)) == '0;
	endproperty
	a_pullup_off: assert property (p_pullup_off) else $error("pull-up on");

	property p_pullup_disable;
		@(posedge i_clock) disable iff (!i_nrst)
		i_global_pullup_disable |-> o_pullup_en == '0;
	endproperty
	a_pullup_disable: assert property (p_pullup_disable) else $error("pull-up despite disable");

	property p_read_pin;
		@(posedge i_clock) disable iff (!i_nrst)
		i_rd_en && (i_rd_sel == GPP_SEL_PIN_INPUT) |=> o_rd_data == $past(port_pin_input);
	endproperty
	a_read_pin: assert property (p_read_pin) else $error("pin read wrong");

	// a read in the cycle of a write returns the old register value
	property p_read_dir;
		@(posedge i_clock) disable iff (!i_nrst)
		i_rd_en && (i_rd_sel == GPP_SEL_DIRECTION) |=> o_rd_data == $past(o_pad_oe);
	endproperty
	a_read_dir: assert property (p_read_dir) else $error("direction read wrong");

	property p_read_out;
		@(posedge i_clock) disable iff (!i_nrst)
		i_rd_en && (i_rd_sel == GPP_SEL_OUTPUT_VALUE) |=> o_rd_data == $past(o_pad_out);
	endproperty
	a_read_out: assert property (p_read_out) else $error("value read wrong");

	property p_unmapped_write;
		@(posedge i_clock) disable iff (!i_nrst)
		i_wr_en && (i_wr_sel == 2'h3) |=> $stable(o_pad_oe) && $stable(o_pad_out);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");

	property p_reset_hiz;
		@(posedge i_clock)
		!i_nrst |-> (o_pad_oe == '0) && (o_pullup_en == '0);
	endproperty
	a_reset_hiz: assert property (p_reset_hiz) else $error("pad driven in reset");

	property p_reset_values;
		@(posedge i_clock) disable iff (!i_nrst)
		$rose(i_nrst) |-> (o_pad_oe == GPP_DIR_RESET) && (o_pad_out == GPP_OUT_RESET);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset value");

endmodule

// ### bench/gpp_pad_model.sv
// gpp_pad_model: board side of the port pads, resolving each pad level
`timescale 1ns/1ps
module gpp_pad_model (
	input  wire logic       i_clock,     // system clock
	input  wire logic [7:0] i_pad_out,   // level the port drives
	input  wire logic [7:0] i_pad_oe,    // port drive enable
	input  wire logic [7:0] i_pullup_en, // port pull-up enable
	input  wire logic [7:0] i_ext_en,    // board driver enable
	input  wire logic [7:0] i_ext_level, // board driver level
	output logic      [7:0] o_pad_level  // resolved pad level
);
	logic [7:0] float_q = 8'h5a;
	// a floating pad wanders every cycle, so no stale level reads as valid
	always @(posedge i_clock) begin
		float_q <= ~float_q;
	end
	// port driver wins, then the board driver, then the pull-up
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			if (i_pad_oe[n])
				o_pad_level[n] = i_pad_out[n];
			else if (i_ext_en[n])
				o_pad_level[n] = i_ext_level[n];
			else if (i_pullup_en[n])
				o_pad_level[n] = 1'b1;
			else
				o_pad_level[n] = float_q[n];
		end
	end
endmodule

// ### bench/gpio_port_pin_control_bench.sv
// gpio_port_pin_control_bench: self-checking bench for the port pin logic
`timescale 1ns/1ps
module gpio_port_pin_control_bench
	import gpp_pkg::*;
;
	logic       i_clock = 1'b0;
	logic       i_nrst  = 1'b0;
	logic       i_wr_en = 1'b0;
	logic [1:0] i_wr_sel = 2'h0;
	logic [7:0] i_wr_data = 8'h00;
	logic [7:0] i_wr_mask = 8'h00;
	logic       i_rd_en = 1'b0;
	logic [1:0] i_rd_sel = 2'h0;
	logic       i_global_pullup_disable = 1'b0;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_level = 8'h00;
	logic [7:0] pad_in, o_rd_data, o_pad_out, o_pad_oe, o_pullup_en, rv;
	int         errors = 0;
	int         cmp_count = 0;
	int         cycles = 0;

	gpp_port gpp_port_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_wr_en(i_wr_en),
		.i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data), .i_wr_mask(i_wr_mask),
		.i_rd_en(i_rd_en), .i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data),
		.i_global_pullup_disable(i_global_pullup_disable), .i_pad_in(pad_in),
		.o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .o_pullup_en(o_pullup_en));
	gpp_pad_model gpp_pad_model_inst (.i_clock(i_clock), .i_pad_out(o_pad_out),
		.i_pad_oe(o_pad_oe), .i_pullup_en(o_pullup_en), .i_ext_en(ext_en),
		.i_ext_level(ext_level), .o_pad_level(pad_in));

	// 50 ns clock
	initial begin
		forever #25 i_clock = ~i_clock;
	end
	// ceiling far above the few dozen cycles the scenarios need; a hang fails
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one write, strobe up for exactly one rising edge
	task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic [7:0] m);
		@(negedge i_clock);
		i_wr_en = 1'b1;
		i_wr_sel = sel;
		i_wr_data = d;
		i_wr_mask = m;
		@(negedge i_clock);
		i_wr_en = 1'b0;
	endtask

	task automatic rd(input logic [1:0] sel, output logic [7:0] d);
		@(negedge i_clock);
		i_rd_en = 1'b1;
		i_rd_sel = sel;
		@(negedge i_clock);
		i_rd_en = 1'b0;
		d = o_rd_data;
	endtask

	task automatic t_reset();
		chk("oe", 8'h00, o_pad_oe);
		chk("pullup", 8'h00, o_pullup_en);
		rd(GPP_SEL_DIRECTION, rv);
		chk("dir", 8'h00, rv);
		rd(GPP_SEL_OUTPUT_VALUE, rv);
		chk("out", 8'h00, rv);
	endtask

	// value first, then direction: bits pass via pull-up or tri-state
	task automatic t_config();
		wr(GPP_SEL_OUTPUT_VALUE, 8'ha5, 8'hff);
		chk("pullup", 8'ha5, o_pullup_en);
		wr(GPP_SEL_DIRECTION, 8'h0f, 8'hff);
		chk("oe", 8'h0f, o_pad_oe);
		chk("pad", 8'ha5, o_pad_out);
		chk("pullup", 8'ha0, o_pullup_en);
		@(negedge i_clock);
		i_global_pullup_disable = 1'b1;
		#1 chk("pullup", 8'h00, o_pullup_en);
		@(negedge i_clock);
		i_global_pullup_disable = 1'b0;
		rd(GPP_SEL_DIRECTION, rv);
		chk("dir", 8'h0f, rv);
	endtask

	task automatic t_toggle();
		wr(GPP_SEL_PIN_INPUT, 8'h81, 8'hff);
		chk("pad", 8'h24, o_pad_out);
		rd(GPP_SEL_DIRECTION, rv);
		chk("dir", 8'h0f, rv);
		wr(GPP_SEL_DIRECTION, 8'h00, 8'h08);
		chk("oe", 8'h07, o_pad_oe);
		chk("pad", 8'h24, o_pad_out);
	endtask

	task automatic t_input();
		ext_en = 8'hf8;
		ext_level = 8'h50;
		repeat (2) @(negedge i_clock);
		rd(GPP_SEL_PIN_INPUT, rv);
		chk("pin", 8'h54, rv);
		wr(GPP_SEL_OUTPUT_VALUE, 8'h03, 8'h07);
		rd(GPP_SEL_PIN_INPUT, rv);
		chk("pin", 8'h53, rv);
	endtask

	task automatic t_unmapped();
		wr(2'h3, 8'hff, 8'hff);
		rd(GPP_SEL_OUTPUT_VALUE, rv);
		chk("out", 8'h23, rv);
		rd(2'h3, rv);
		chk("unmapped", GPP_UNMAPPED_READ, rv);
	endtask

	// reset lands between edges; pins must release without a clock edge
	task automatic t_async_reset();
		@(negedge i_clock);
		i_nrst = 1'b0;
		#5 chk("oe", 8'h00, o_pad_oe);
		chk("pad", 8'h00, o_pad_out);
		chk("pullup", 8'h00, o_pullup_en);
		@(negedge i_clock);
		i_nrst = 1'b1;
		rd(GPP_SEL_DIRECTION, rv);
		chk("dir", 8'h00, rv);
	endtask

	initial begin
		repeat (2) @(negedge i_clock);
		i_nrst = 1'b1;
		t_reset();
		t_config();
		t_toggle();
		t_input();
		t_unmapped();
		t_async_reset();
		give_verdict();
	end
endmodule
